// [core/rcpm_pkg.sv]
package rcpm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          RCPM_AW          = 4;
  localparam int          RCPM_DW          = 32;
  localparam logic [3:0]  RCPM_ADDR_STRAP  = 4'h0;
  localparam logic [3:0]  RCPM_ADDR_MUX    = 4'h4;
  localparam logic [3:0]  RCPM_ADDR_IRQSEL = 4'h8;
  localparam logic [3:0]  RCPM_ADDR_STAT   = 4'hC;

  // ----------------------------------------------------------------
  // Pin layout
  // ----------------------------------------------------------------
  localparam int          RCPM_PINS        = 64;
  localparam int          RCPM_NSTRAP      = 6;
  localparam int          RCPM_BIT_WDOG    = 0;
  localparam int          RCPM_BIT_SYNC    = 1;
  localparam int          RCPM_BIT_WIDTH   = 2;
  localparam int          RCPM_BIT_CKA     = 3;
  localparam int          RCPM_BIT_CKB     = 4;
  localparam int          RCPM_BIT_CFGS    = 5;
  localparam int          RCPM_RX_LO       = 40;
  localparam int          RCPM_RX_HI       = 42;
  localparam int          RCPM_RSV_A_LO    = 32;
  localparam int          RCPM_RSV_A_N     = 8;
  localparam int          RCPM_RSV_B_LO    = 44;
  localparam int          RCPM_RSV_B_N     = 2;
  localparam int          RCPM_HALF        = 32;
  localparam int          RCPM_NIRQ        = 15;
  localparam logic [14:0] RCPM_IRQ_EN_RST  = 15'h007F;
  localparam logic [3:0]  RCPM_DUP_MASK    = 4'hF;

  // ----------------------------------------------------------------
  // Mux control fields
  // ----------------------------------------------------------------
  localparam int          RCPM_MUX_HOST    = 0;
  localparam int          RCPM_MUX_ETH     = 1;
  localparam int          RCPM_MUX_RMII    = 2;
  localparam int          RCPM_MUX_DIR     = 3;

  typedef enum logic [1:0] {
    RCPM_ST_RESET,
    RCPM_ST_SAMPLE,
    RCPM_ST_RUN
  } rcpm_state_e;

  typedef struct packed {
    logic config_source_strap;
    logic clock_mode_strap_b;
    logic clock_mode_strap_a;
    logic bus_width_strap;
    logic host_port_sync_strap;
    logic watchdog_disable_strap;
  } rcpm_strap_s;

  typedef struct packed {
    logic eth_receive_bit3;
    logic eth_receive_bit2;
    logic eth_receive_bit1;
    logic eth_receive_bit0;
  } rcpm_ethrx_s;

endpackage

// [core/rcpm_top.sv]
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
// Operation
// (RL1) Shared pins follow the assignment held in internal configuration registers.
// (RL2) Watchdog disable strap is latched from host data bit 0 at reset release.
// (RL3) Host port sync strap is latched from host data bit 1 at reset release.
// (RL4) Bus width strap is latched from host data bit 2 at reset release.
// (RL5) Two clock mode straps are latched from host data bits 3 and 4.
// (RL6) Configuration source strap is latched from host data bit 5.
// (RL7) After reset only interrupts 1 to 7 are enabled; 1,2,3,7 have two lines.
// (RL8) Software picks one duplicate line per interrupt and reuses the other.
// (RL9) Interrupts 8 to 15 and extra alternates come only through GPIO pins.
// (RL10) Writes: master drives upper data lines; reads: slave drives them.
// (RL11) Ethernet receive bits 0 and 1 come from data pins 40 and 41.
// (RL12) Only in MII mode receive bits 2 and 3 come from pins 42 and 43.
// (RL13) In RMII mode pins for receive bits 2 and 3 are ignored.
// (RL14) With Ethernet muxed on, pins 32 to 39 and 44 to 45 are ignored.
// (RL15) The block stays in reset state while power-on reset input is asserted.
// (RL16) Latched straps hold constant until power-on reset asserts again.
module rcpm_top
  import rcpm_pkg::*;
#(
  parameter int PINS = RCPM_PINS
) (
  input  wire logic               I_CLK,
  input  wire logic               I_RSTN,
  input  wire logic               I_CE,
  input  wire logic               I_POWER_ON_RESET_IN_N,
  input  wire logic [PINS-1:0]    I_HOST_PORT_DATA,
  input  wire logic [PINS-1:0]    I_HOST_PORT_DATA_OUT,
  input  wire logic [PINS-1:0]    I_SYS_DATA_OUT,
  input  wire logic               I_SYS_WRITE,
  input  wire logic               I_HOST_READ,
  input  wire logic [3:0]         I_DUP_LINE_A,
  input  wire logic [3:0]         I_DUP_LINE_B,
  input  wire logic [7:0]         I_GPIO_IRQ,
  input  wire logic [RCPM_AW-1:0] I_ADDR,
  input  wire logic [RCPM_DW-1:0] I_WDATA,
  input  wire logic               I_WR,
  input  wire logic               I_RD,
  output logic [RCPM_DW-1:0]      O_RDATA,
  output logic [PINS-1:0]         O_HOST_PORT_DATA,
  output logic [PINS-1:0]         O_HOST_PORT_DATA_OE,
  output logic [PINS-1:0]         O_HOST_DATA_IN,
  output logic [PINS-1:0]         O_SYS_DATA_IN,
  output rcpm_ethrx_s             O_ETH_RX,
  output rcpm_strap_s             O_STRAPS,
  output logic                    O_STRAP_VALID,
  output logic [RCPM_NIRQ-1:0]    O_IRQ
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PINS-1:0] pin_s1_q;
  logic [PINS-1:0] pin_s2_q;
  logic [PINS-1:0] pin_s3_q;
  logic [PINS-1:0] pin_q;
  logic [2:0]      por_s_q;
  logic            por_q;
  logic [15:0]     irqin_s1_q;
  logic [15:0]     irqin_s2_q;
  logic [15:0]     irqin_s3_q;
  logic [15:0]     irqin_q;

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      pin_s1_q   <= '0;
      pin_s2_q   <= '0;
      pin_s3_q   <= '0;
      pin_q      <= '0;
      por_s_q    <= '0;
      por_q      <= 1'b0;
      irqin_s1_q <= '0;
      irqin_s2_q <= '0;
      irqin_s3_q <= '0;
      irqin_q    <= '0;
    end else if (I_CE) begin
      pin_s1_q   <= I_HOST_PORT_DATA;
      pin_s2_q   <= pin_s1_q;
      pin_s3_q   <= pin_s2_q;
      por_s_q    <= {por_s_q[1:0], I_POWER_ON_RESET_IN_N};
      irqin_s1_q <= {I_GPIO_IRQ, I_DUP_LINE_B, I_DUP_LINE_A};
      irqin_s2_q <= irqin_s1_q;
      irqin_s3_q <= irqin_s2_q;
      for (int i = 0; i < PINS; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_q[i] <= pin_s2_q[i];
        end
      end
      for (int i = 0; i < 16; i++) begin
        if (irqin_s2_q[i] == irqin_s3_q[i]) begin
          irqin_q[i] <= irqin_s2_q[i];
        end
      end
      if (por_s_q[1] == por_s_q[2]) begin
        por_q <= por_s_q[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset sequence and strap capture
  // ----------------------------------------------------------------
  rcpm_state_e state_q;
  rcpm_strap_s strap_q;

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      state_q <= RCPM_ST_RESET;
    end else if (I_CE) begin
      case (state_q)
        RCPM_ST_RESET: begin
          if (por_q) begin
            state_q <= RCPM_ST_SAMPLE;
          end
        end
        RCPM_ST_SAMPLE: begin
          state_q <= por_q ? RCPM_ST_RUN : RCPM_ST_RESET;
        end
        RCPM_ST_RUN: begin
          if (!por_q) begin
            state_q <= RCPM_ST_RESET; // RL15
          end
        end
        default: begin
          state_q <= RCPM_ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      strap_q <= '0;
    end else if (I_CE && state_q == RCPM_ST_SAMPLE) begin // RL16
      strap_q.watchdog_disable_strap <= pin_q[RCPM_BIT_WDOG];  // RL2
      strap_q.host_port_sync_strap   <= pin_q[RCPM_BIT_SYNC];  // RL3
      strap_q.bus_width_strap        <= pin_q[RCPM_BIT_WIDTH]; // RL4
      strap_q.clock_mode_strap_a     <= pin_q[RCPM_BIT_CKA];   // RL5
      strap_q.clock_mode_strap_b     <= pin_q[RCPM_BIT_CKB];   // RL5
      strap_q.config_source_strap    <= pin_q[RCPM_BIT_CFGS];  // RL6
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [3:0]           mux_q;
  logic [RCPM_NIRQ-1:0] irq_en_q;
  logic [3:0]           dup_sel_q;
  logic                 run;

  assign run = (state_q == RCPM_ST_RUN);

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN || (I_CE && !run)) begin
      mux_q     <= '0;
      irq_en_q  <= RCPM_IRQ_EN_RST; // RL7
      dup_sel_q <= '0;
    end else if (I_CE && I_WR) begin
      if (I_ADDR == RCPM_ADDR_MUX) begin
        mux_q <= I_WDATA[3:0]; // RL1
      end
      if (I_ADDR == RCPM_ADDR_IRQSEL) begin
        irq_en_q  <= I_WDATA[RCPM_NIRQ-1:0];
        dup_sel_q <= I_WDATA[RCPM_HALF-1 -: 4] & RCPM_DUP_MASK; // RL8
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_RDATA <= '0;
    end else if (I_CE) begin
      O_RDATA <= '0;
      if (I_RD) begin
        case (I_ADDR)
          RCPM_ADDR_STRAP:  O_RDATA <= {{(RCPM_DW-RCPM_NSTRAP){1'b0}}, strap_q};
          RCPM_ADDR_MUX:    O_RDATA <= {28'h0000000, mux_q};
          RCPM_ADDR_IRQSEL: O_RDATA <= {dup_sel_q, 13'h0, irq_en_q};
          RCPM_ADDR_STAT:   O_RDATA <= {30'h0, por_q, run};
          default:          O_RDATA <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------
  logic [PINS-1:0] ign;
  logic            eth_on;
  logic            wide;

  assign eth_on = mux_q[RCPM_MUX_ETH];
  assign wide   = strap_q.bus_width_strap;

  always_comb begin
    ign = '0;
    if (!wide) begin
      ign[PINS-1:RCPM_HALF] = '1;
    end
    if (eth_on) begin
      ign[RCPM_RSV_A_LO +: RCPM_RSV_A_N] = '1; // RL14
      ign[RCPM_RSV_B_LO +: RCPM_RSV_B_N] = '1; // RL14
      ign[RCPM_RX_LO +: 4]               = '1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN || (I_CE && !run)) begin
      O_HOST_PORT_DATA    <= '0;
      O_HOST_PORT_DATA_OE <= '0;
      O_HOST_DATA_IN      <= '0;
      O_SYS_DATA_IN       <= '0;
      O_ETH_RX            <= '0;
    end else if (I_CE) begin
      if (mux_q[RCPM_MUX_HOST]) begin // RL1
        O_HOST_PORT_DATA    <= I_HOST_PORT_DATA_OUT & ~ign;
        O_HOST_PORT_DATA_OE <= {PINS{I_HOST_READ}} & ~ign;
        O_HOST_DATA_IN      <= pin_q & ~ign;
        O_SYS_DATA_IN       <= '0;
      end else begin
        O_HOST_PORT_DATA    <= I_SYS_DATA_OUT & ~ign;
        O_HOST_PORT_DATA_OE <= {PINS{I_SYS_WRITE ^ mux_q[RCPM_MUX_DIR]}} & ~ign; // RL10
        O_SYS_DATA_IN       <= pin_q & ~ign;
        O_HOST_DATA_IN      <= '0;
      end
      if (eth_on) begin
        O_ETH_RX.eth_receive_bit0 <= pin_q[RCPM_RX_LO];     // RL11
        O_ETH_RX.eth_receive_bit1 <= pin_q[RCPM_RX_LO + 1]; // RL11
        O_ETH_RX.eth_receive_bit2 <= mux_q[RCPM_MUX_RMII] ? 1'b0 : pin_q[RCPM_RX_HI];     // RL12 RL13
        O_ETH_RX.eth_receive_bit3 <= mux_q[RCPM_MUX_RMII] ? 1'b0 : pin_q[RCPM_RX_HI + 1]; // RL12 RL13
      end else begin
        O_ETH_RX <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt line selection
  // ----------------------------------------------------------------
  logic [RCPM_NIRQ-1:0] irq_raw;

  always_comb begin
    irq_raw = '0;
    irq_raw[6:0] = {dup_sel_q[3] ? irqin_q[7] : irqin_q[3], 3'b000,
                    dup_sel_q[2] ? irqin_q[6] : irqin_q[2],
                    dup_sel_q[1] ? irqin_q[5] : irqin_q[1],
                    dup_sel_q[0] ? irqin_q[4] : irqin_q[0]}; // RL7
    irq_raw[14:7] = irqin_q[15:8]; // RL9
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_IRQ         <= '0;
      O_STRAPS      <= '0;
      O_STRAP_VALID <= 1'b0;
    end else if (I_CE) begin
      O_IRQ         <= run ? (irq_raw & irq_en_q) : '0;
      O_STRAPS      <= strap_q;
      O_STRAP_VALID <= run;
    end
  end

endmodule

// [bench/rcpm_top_assertions.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module rcpm_top_chk
  import rcpm_pkg::*;
#(
  parameter int PINS = RCPM_PINS
) (
  input wire logic                 I_CLK,
  input wire logic                 I_RSTN,
  input wire logic                 I_CE,
  input wire logic                 I_POWER_ON_RESET_IN_N,
  input wire logic [RCPM_AW-1:0]   I_ADDR,
  input wire logic                 I_RD,
  input wire logic [RCPM_DW-1:0]   O_RDATA,
  input wire logic [PINS-1:0]      O_HOST_DATA_IN,
  input wire logic [PINS-1:0]      O_SYS_DATA_IN,
  input wire rcpm_strap_s          O_STRAPS,
  input wire logic                 O_STRAP_VALID,
  input wire logic [RCPM_NIRQ-1:0] O_IRQ
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);

  property p_idle; $past(I_CE) && !$past(I_RD) |-> O_RDATA == '0; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_excl; !((|O_HOST_DATA_IN) && (|O_SYS_DATA_IN)); endproperty
  a_excl: assert property (p_excl) else $error("pins routed to both ports");
  property p_hold; O_STRAP_VALID && $past(O_STRAP_VALID) |-> $stable(O_STRAPS); endproperty
  a_hold: assert property (p_hold) else $error("straps changed in run");
  property p_drop; $fell(I_POWER_ON_RESET_IN_N) |-> ##[1:8] !O_STRAP_VALID; endproperty
  a_drop: assert property (p_drop) else $error("power-on reset not entered");
  property p_rise; $rose(O_STRAP_VALID) |-> $past(I_POWER_ON_RESET_IN_N, 3); endproperty
  a_rise: assert property (p_rise) else $error("run entered too early");
  property p_noirq; O_IRQ[5:3] == 3'h0; endproperty
  a_noirq: assert property (p_noirq) else $error("unsourced interrupt set");
  property p_narrow;
    O_STRAP_VALID && $past(O_STRAP_VALID) && !O_STRAPS.bus_width_strap
      |-> O_SYS_DATA_IN[PINS-1:RCPM_HALF] == '0 && O_HOST_DATA_IN[PINS-1:RCPM_HALF] == '0;
  endproperty
  a_narrow: assert property (p_narrow) else $error("upper lines used in narrow mode");
  property p_rdstrap;
    $past(I_CE) && $past(I_RD) && $past(I_ADDR) == RCPM_ADDR_STRAP && $past(O_STRAP_VALID)
      |-> O_RDATA == {26'h0, $past(O_STRAPS)};
  endproperty
  a_rdstrap: assert property (p_rdstrap) else $error("strap readback wrong");
endmodule

bind rcpm_top rcpm_top_chk #(.PINS(PINS)) i_chk (.*);

// [bench/rcpm_far_end.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Host side of the shared data pins
// ----------------------------------------------------------------
module rcpm_far_end #(
  parameter int PINS = 64
) (
  input  wire logic [PINS-1:0] i_drive,
  input  wire logic [PINS-1:0] i_dev_data,
  input  wire logic [PINS-1:0] i_dev_oe,
  output logic      [PINS-1:0] o_pin
);
  // The host drives a line only while the device leaves it free.
  assign o_pin = (i_dev_oe & i_dev_data) | (~i_dev_oe & i_drive);
endmodule

// [bench/testbench.sv]
`timescale 1ns/100ps
module testbench
  import rcpm_pkg::*;
;
  localparam logic [63:0] pat_a = 64'hA5A5_0F0F_1234_5678;
  localparam logic [63:0] pat_b = 64'h0123_4567_89AB_CDEF;
  localparam logic [63:0] ones  = 64'hFFFF_FFFF_FFFF_FFFF;
  logic        clk, rst_n = 1'h0, por_n = 1'h0, sys_wr = 1'h0, host_rd = 1'h0;
  logic        wr = 1'h0, rd = 1'h0, valid, ce = 1'h1;
  logic [63:0] drv = 64'h2D, host_out = 64'h0, sys_out = 64'h0;
  logic [63:0] pins, hp_data, hp_oe, host_in, sys_in;
  logic [3:0]  dup_a = 4'h0, dup_b = 4'h0, addr = 4'h0;
  logic [7:0]  gpio = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [14:0] irq;
  rcpm_ethrx_s eth;
  rcpm_strap_s straps;
  int          num_errors = 0, checks = 0, cycles = 0;

  rcpm_top i_dut (
    .I_CLK(clk), .I_RSTN(rst_n), .I_CE(ce), .I_POWER_ON_RESET_IN_N(por_n),
    .I_HOST_PORT_DATA(pins), .I_HOST_PORT_DATA_OUT(host_out), .I_SYS_DATA_OUT(sys_out),
    .I_SYS_WRITE(sys_wr), .I_HOST_READ(host_rd), .I_DUP_LINE_A(dup_a), .I_DUP_LINE_B(dup_b),
    .I_GPIO_IRQ(gpio), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .O_HOST_PORT_DATA(hp_data), .O_HOST_PORT_DATA_OE(hp_oe), .O_HOST_DATA_IN(host_in),
    .O_SYS_DATA_IN(sys_in), .O_ETH_RX(eth), .O_STRAPS(straps), .O_STRAP_VALID(valid), .O_IRQ(irq)
  );
  rcpm_far_end i_far (.i_drive(drv), .i_dev_data(hp_data), .i_dev_oe(hp_oe), .o_pin(pins));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic end_of_test();
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic set_pins(input logic [63:0] v);
    @(posedge clk);
    drv <= v;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    chk(rdata, e);
  endtask

  task automatic wait_valid();
    for (int i = 0; i < 20 && valid !== 1'h1; i++) @(negedge clk);
    chk(valid, 1'h1);
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    cyc(4);
    chk(valid, 1'h0);
    chk(straps, 6'h00);
    @(posedge clk);
    por_n <= 1'h1;
    wait_valid();
    chk(straps, 6'h2D);
    rd_reg(RCPM_ADDR_STRAP, 32'h2D);
    rd_reg(RCPM_ADDR_IRQSEL, 32'h7F);
    rd_reg(4'h2, 32'h0);
    set_pins(64'h12);
    cyc(8);
    chk(straps, 6'h2D);
    wr_reg(RCPM_ADDR_MUX, 32'h1);
    set_pins(pat_a);
    cyc(6);
    chk(host_in, pat_a);
    chk(sys_in, 64'h0);
    @(posedge clk);
    host_rd <= 1'h1;
    host_out <= pat_b;
    cyc(3);
    chk(hp_oe, ones);
    chk(hp_data, pat_b);
    @(posedge clk);
    host_rd <= 1'h0;
    sys_wr <= 1'h1;
    sys_out <= pat_a;
    wr_reg(RCPM_ADDR_MUX, 32'h0);
    cyc(3);
    chk(hp_oe, ones);
    chk(hp_data, pat_a);
    @(posedge clk);
    sys_wr <= 1'h0;
    drv <= pat_b;
    cyc(8);
    chk(hp_oe, 64'h0);
    chk(sys_in, pat_b);
    wr_reg(RCPM_ADDR_MUX, 32'h2);
    cyc(6);
    chk(eth, pat_b[43:40]);
    chk(sys_in, pat_b & 64'hFFFF_C000_FFFF_FFFF);
    wr_reg(RCPM_ADDR_MUX, 32'h6);
    cyc(6);
    chk(eth, {2'h0, pat_b[41:40]});
    @(posedge clk);
    dup_a <= 4'hF;
    gpio <= 8'hFF;
    cyc(8);
    chk(irq, 15'h0047);
    wr_reg(RCPM_ADDR_IRQSEL, 32'hF000_7FFF);
    cyc(8);
    chk(irq, 15'h7F80);
    @(posedge clk);
    por_n <= 1'h0;
    drv <= 64'h12;
    cyc(8);
    chk(valid, 1'h0);
    chk(straps, 6'h2D);
    rd_reg(RCPM_ADDR_IRQSEL, 32'h7F);
    @(posedge clk);
    por_n <= 1'h1;
    wait_valid();
    chk(straps, 6'h12);
    set_pins(ones);
    cyc(6);
    chk(sys_in, 64'h0000_0000_FFFF_FFFF);
    @(posedge clk);
    ce <= 1'h0;
    drv <= 64'h0;
    cyc(8);
    chk(sys_in, 64'h0000_0000_FFFF_FFFF);
    @(posedge clk);
    ce <= 1'h1;
    cyc(6);
    chk(sys_in, 64'h0);
    end_of_test();
  end
endmodule
